// ==== spi_far_end.sv ====
`timescale 1ns/1ns
module spi_far_end (
  // design pins
  input wire spi_port_pkg::pin_out_type pins_out,
  output spi_port_pkg::pin_in_type pins_in
);
  logic m_sck = 1'b0;
  logic m_mosi = 1'b0;
  logic nss_q = 1'b1;
  logic [7:0] stx = 8'h00;
  logic [7:0] srx = 8'h00;

  // ----
  // wire levels from both drivers
  // ----
  assign pins_in.sck = pins_out.sck_oe ? pins_out.sck_out : m_sck;
  assign pins_in.mosi = pins_out.mosi_oe ? pins_out.mosi_out : m_mosi;
  assign pins_in.miso = pins_out.miso_oe ? pins_out.miso_out : stx[7];
  assign pins_in.slave_select_pin = pins_out.nss_oe ? pins_out.nss_out : nss_q;

  // slave side: one device only, no extra selects
  always @(posedge pins_in.sck) begin
    srx <= {srx[6:0], pins_in.mosi};
  end

  // slave shifts out on the falling edge
  always @(negedge pins_in.sck) begin
    stx <= {stx[6:0], ~stx[0]};
  end

  // master side: one mode 0 byte, 80 ns link clock
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    nss_q = 1'b0;
    #40;
    for (int i = 7; i >= 0; i--) begin
      m_mosi = d[i];
      #40 m_sck = 1'b1;
      q[i] = pins_in.miso;
      #40 m_sck = 1'b0;
    end
    m_mosi = ~m_mosi; // no stale bit after the frame
    nss_q = 1'b1;
  endtask : xfer
endmodule : spi_far_end

// ==== spi_master_slave_port.sv ====
`timescale 1ns/1ns
module spi_master_slave_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // software data access
  input wire logic data_wr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rx_data,
  // software control access
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic irq_enable,
  output logic [7:0] ctrl_status,
  output logic irq,
  // serial pins
  input wire spi_port_pkg::pin_in_type pins_in,
  output spi_port_pkg::pin_out_type pins_out
);

  // ------------------------------------------------------------
  // state and pin synchronisation
  // ------------------------------------------------------------
  spi_port_pkg::state_type r;
  spi_port_pkg::state_type n;
  spi_port_pkg::pin_in_type s;

  logic tick;
  logic rise;
  logic fall;
  logic multi_mm;
  logic slave_active;
  logic move;
  logic fault_hit;

  spi_pin_sync #(
    .WIDTH(4)
  ) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in(pins_in),
    .sync_out(s)
  );

  // ------------------------------------------------------------
  // decoded conditions
  // ------------------------------------------------------------
  // divider enable, one pulse per half sck period
  assign tick = (r.div == spi_port_pkg::SCK_HALF_CYCLES - 4'h1);
  // edges of the external sck seen in our clock domain
  assign rise = s.sck & ~r.sck_prev;
  assign fall = ~s.sck & r.sck_prev;
  // multi-master select mode, select pin is an input
  assign multi_mm = ~r.sel_hi & r.sel_lo;
  // slave selected: 3-wire ignores the select pin
  assign slave_active = r.pen & ~r.men &
    ((~r.sel_hi & ~r.sel_lo) | ~s.slave_select_pin);
  // buffered byte may enter an empty shifter
  assign move = r.tx_full & ~r.shift_full &
    (r.st == spi_port_pkg::ST_IDLE);
  // another master pulled select low
  assign fault_hit = multi_mm & r.men & ~s.slave_select_pin;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    n = r;
    n.sck_prev = s.sck;

    // software control write; flags only clear by writing 0
    if (ctrl_wr) begin
      n.men = ctrl_wdata[spi_port_pkg::MEN_BIT];
      n.pen = ctrl_wdata[spi_port_pkg::PEN_BIT];
      n.sel_hi = ctrl_wdata[spi_port_pkg::SEL_HI_BIT];
      n.sel_lo = ctrl_wdata[spi_port_pkg::SEL_LO_BIT];
      n.done = r.done & ctrl_wdata[spi_port_pkg::DONE_BIT];
      n.fault = r.fault & ctrl_wdata[spi_port_pkg::FAULT_BIT];
    end

    // transmit buffer into empty shift register
    if (move) begin
      n.shift = r.txbuf;
      n.shift_full = 1'b1;
      n.tx_full = 1'b0;
      n.pins.mosi_out = r.txbuf[7];
      n.pins.miso_out = r.txbuf[7];
      if (n.men && n.pen) begin
        n.st = spi_port_pkg::ST_RUN;
        n.div = 4'h0;
        n.bitcnt = 3'h0;
      end
    end

    // software write lands in transmit buffer only
    if (data_wr) begin
      n.txbuf = wr_data;
      n.tx_full = 1'b1;
    end

    unique case (r.st)
      spi_port_pkg::ST_IDLE: begin
        n.div = 4'h0;
        n.pins.sck_out = 1'b0;
        // slave shifting under the external clock
        if (slave_active) begin
          if (rise) begin
            n.shift = {r.shift[6:0], s.mosi};
            n.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == spi_port_pkg::LAST_BIT) begin
              n.rxbuf = {r.shift[6:0], s.mosi};
              n.done = 1'b1;
              n.shift_full = 1'b0;
              n.bitcnt = 3'h0;
            end
          end
          if (fall) begin
            n.pins.miso_out = r.shift[7];
          end
        end else if (!r.men) begin
          n.bitcnt = 3'h0;
        end
      end
      spi_port_pkg::ST_RUN: begin
        // master shifting under the divided clock
        n.div = r.div + 4'h1;
        if (tick) begin
          n.div = 4'h0;
          n.pins.sck_out = ~r.pins.sck_out;
          if (!r.pins.sck_out) begin
            n.shift = {r.shift[6:0], s.miso};
          end else begin
            n.pins.mosi_out = r.shift[7];
            n.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == spi_port_pkg::LAST_BIT) begin
              n.st = spi_port_pkg::ST_IDLE;
              n.rxbuf = r.shift;
              n.done = 1'b1;
              n.shift_full = 1'b0;
              n.bitcnt = 3'h0;
            end
          end
        end
      end
      default: begin
        n.st = spi_port_pkg::ST_IDLE;
      end
    endcase

    // dropping either enable ends a running master transfer
    if (r.st == spi_port_pkg::ST_RUN && !(n.men && n.pen)) begin
      n.st = spi_port_pkg::ST_IDLE;
      n.shift_full = 1'b0;
      n.bitcnt = 3'h0;
      n.div = 4'h0;
    end

    // mode fault drops both enables and aborts
    if (fault_hit) begin
      n.men = 1'b0;
      n.pen = 1'b0;
      n.fault = 1'b1;
      n.st = spi_port_pkg::ST_IDLE;
      n.pins.sck_out = 1'b0;
      n.shift_full = 1'b0;
      n.bitcnt = 3'h0;
    end

    // pin drivers
    n.pins.sck_oe = n.men & n.pen;
    n.pins.mosi_oe = n.men & n.pen;
    n.pins.miso_oe = ~n.men & n.pen & ((~n.sel_hi & ~n.sel_lo) | ~s.slave_select_pin);
    n.pins.nss_oe = n.sel_hi & n.pen;
    n.pins.nss_out = n.sel_hi ? n.sel_lo : 1'b1;
    if (!n.pins.sck_oe) begin
      n.pins.sck_out = 1'b0;
    end

    // interrupt request from either flag
    n.irq = irq_enable & (n.done | n.fault);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r <= spi_port_pkg::STATE_RESET;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign rx_data = r.rxbuf;
  assign ctrl_status = {r.done, r.men, r.fault, 1'b0,
    r.sel_hi, r.sel_lo, 1'b0, r.pen};
  assign irq = r.irq;
  assign pins_out = r.pins;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_slave_no_clock: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !r.men |-> !r.pins.sck_oe && r.st == spi_port_pkg::ST_IDLE)
    else $error("slave drives sck or runs a transfer");

  a_slave_byte_done: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    slave_active && rise && !fault_hit &&
    r.bitcnt == spi_port_pkg::LAST_BIT
    |=> r.done && rx_data == $past({r.shift[6:0], s.mosi}))
    else $error("slave byte not completed after eight edges");

  a_master_rx_buf: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    r.st == spi_port_pkg::ST_RUN && tick && r.pins.sck_out &&
    r.bitcnt == spi_port_pkg::LAST_BIT && !fault_hit
    |=> rx_data == $past(r.shift) && r.done &&
    r.st == spi_port_pkg::ST_IDLE)
    else $error("master byte not moved to receive buffer");

  a_tx_load: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    move && !fault_hit |=> r.shift_full && r.shift == $past(r.txbuf))
    else $error("buffered byte not loaded into shifter");

  a_tx_wait: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    r.shift_full && data_wr |=> r.tx_full && r.txbuf == $past(wr_data))
    else $error("byte lost while shifter busy");

  a_master_start: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    move && r.men && r.pen && !fault_hit && !ctrl_wr
    |=> r.st == spi_port_pkg::ST_RUN ##[1:4] r.pins.sck_out)
    else $error("master transfer did not start");

  a_master_drives: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    r.st == spi_port_pkg::ST_RUN |-> r.pins.sck_oe && r.pins.mosi_oe)
    else $error("master transfer without pin drive");

  a_mode_fault: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    fault_hit |=> r.fault && !r.men && !r.pen && !r.pins.sck_oe)
    else $error("mode fault not taken");

  a_nss_drive: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    r.sel_hi && r.pen |-> r.pins.nss_oe && r.pins.nss_out == r.sel_lo)
    else $error("select output does not follow low bit");

  a_nss_unused: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !r.sel_hi |-> !r.pins.nss_oe)
    else $error("select pin driven outside 4-wire mode");

  a_irq_done: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $rose(r.done) && $past(irq_enable) |-> r.irq)
    else $error("no interrupt on done flag");

  // ------------------------------------------------------------
  // assertions: counters, flags and aborts
  // ------------------------------------------------------------
  a_rx_on_done: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $changed(rx_data) |-> r.done)
    else $error("receive buffer changed without done flag");

  a_done_stands: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    r.done && !ctrl_wr |=> r.done)
    else $error("done flag cleared without a control write");

  a_fault_stands: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    r.fault && !ctrl_wr |=> r.fault)
    else $error("fault flag cleared without a control write");

  a_no_reenable: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !r.men && !ctrl_wr |=> !r.men)
    else $error("master enable restored without software");

  a_multi_input: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    multi_mm |-> !r.pins.nss_oe)
    else $error("select pin driven in multi-master mode");

  a_mosi_first: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    move |=> r.pins.mosi_out == $past(r.txbuf[7]))
    else $error("first bit not on mosi when byte loads");

  a_sck_rate: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    r.st == spi_port_pkg::ST_RUN && !tick && !fault_hit && !ctrl_wr
    |=> $stable(r.pins.sck_out))
    else $error("master sck moved between divider ticks");

  a_irq_fault: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $rose(r.fault) && $past(irq_enable) |-> r.irq)
    else $error("no interrupt on mode fault");

  a_abort_disable: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    r.st == spi_port_pkg::ST_RUN && ctrl_wr &&
    !ctrl_wdata[spi_port_pkg::MEN_BIT]
    |=> r.st == spi_port_pkg::ST_IDLE && !r.pins.sck_oe)
    else $error("master transfer kept running after disable");

  a_slave_count: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    slave_active && rise && !fault_hit &&
    r.bitcnt != spi_port_pkg::LAST_BIT
    |=> r.bitcnt == $past(r.bitcnt) + 3'h1)
    else $error("slave bit count did not advance on sck rise");

  a_master_count: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    r.st == spi_port_pkg::ST_RUN && tick && r.pins.sck_out &&
    !fault_hit && !ctrl_wr && r.bitcnt != spi_port_pkg::LAST_BIT
    |=> r.bitcnt == $past(r.bitcnt) + 3'h1)
    else $error("master bit count did not advance on falling sck");

endmodule : spi_master_slave_port

// ==== spi_master_slave_port_tb_top.sv ====
`timescale 1ns/1ns
module spi_master_slave_port_tb_top;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic data_wr = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] rx_data;
  logic ctrl_wr = 1'b0;
  logic [7:0] ctrl_wdata = 8'h00;
  logic irq_enable = 1'b0;
  logic [7:0] ctrl_status;
  logic irq;
  spi_port_pkg::pin_in_type pins_in;
  spi_port_pkg::pin_out_type pins_out;
  int err_count = 0;
  int n_checks = 0;
  int seed = 32'h97e9;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] q;

  spi_master_slave_port i_spi_master_slave_port (
    .core_clk(core_clk), .sys_rst(sys_rst), .data_wr(data_wr),
    .wr_data(wr_data), .rx_data(rx_data), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .irq_enable(irq_enable),
    .ctrl_status(ctrl_status), .irq(irq), .pins_in(pins_in),
    .pins_out(pins_out));

  spi_far_end i_spi_far_end (.pins_out(pins_out), .pins_in(pins_in));

  // 100 mhz clock
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // ----
  // helpers
  // ----
  // status byte from {done,men,fault,sel_hi,sel_lo,pen}
  function automatic logic [7:0] st(input logic [5:0] f);
    return {f[5:3], 1'b0, f[2:1], 1'b0, f[0]};
  endfunction : st

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic ctrl(input logic [7:0] v);
    @(posedge core_clk);
    ctrl_wr <= 1'b1;
    ctrl_wdata <= v;
    @(posedge core_clk);
    ctrl_wr <= 1'b0;
    repeat (2) @(negedge core_clk);
  endtask : ctrl

  task automatic dwr(input logic [7:0] v);
    @(posedge core_clk);
    data_wr <= 1'b1;
    wr_data <= v;
    @(posedge core_clk);
    data_wr <= 1'b0;
    @(negedge core_clk);
  endtask : dwr

  // bounded wait for the done flag, then check it
  task automatic wait_done;
    int n;
    n = 0;
    while (ctrl_status[spi_port_pkg::DONE_BIT] !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    chk({7'h00, ctrl_status[spi_port_pkg::DONE_BIT]}, 8'h01);
    repeat (2) @(negedge core_clk);
  endtask : wait_done

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // watchdog far beyond the expected run
  initial begin
    #400000;
    err_count++;
    close_out();
  end

  // ----
  // tests
  // ----
  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    chk(ctrl_status, st(6'h02));
    $display("test reset done");
    ctrl(st(6'h11));
    chk(ctrl_status, st(6'h11));
    for (int k = 0; k < 6; k++) begin
      a = (k == 0) ? 8'hff : 8'($random(seed));
      b = (k == 1) ? 8'h00 : 8'($random(seed));
      @(posedge core_clk);
      irq_enable <= k[0];
      i_spi_far_end.stx <= b;
      dwr(a);
      wait_done();
      chk(i_spi_far_end.srx, a);
      chk(rx_data, b);
      chk({7'h00, irq}, {7'h00, irq_enable});
      chk({7'h00, pins_out.nss_oe}, 8'h00);
      ctrl(st(6'h11));
    end
    a = 8'($random(seed));
    b = 8'($random(seed));
    dwr(a);
    dwr(b);
    wait_done();
    chk(i_spi_far_end.srx, a);
    ctrl(st(6'h11));
    wait_done();
    chk(i_spi_far_end.srx, b);
    $display("test master done");
    for (int s = 0; s < 2; s++) begin
      ctrl(st({4'h5, 1'(s), 1'b1}));
      b = {6'h00, pins_out.nss_oe, pins_out.nss_out};
      chk(b, {7'h01, 1'(s)});
    end
    $display("test select done");
    for (int k = 0; k < 2; k++) begin
      ctrl(st({4'h0, 1'(k), 1'b1}));
      a = 8'($random(seed));
      b = 8'($random(seed));
      dwr(a);
      repeat (20) @(negedge core_clk);
      chk({6'h00, pins_out.sck_oe, ctrl_status[7]}, 8'h00);
      i_spi_far_end.xfer(b, q);
      chk(q, a);
      wait_done();
      chk(rx_data, b);
    end
    $display("test slave done");
    ctrl(st(6'h13));
    @(posedge core_clk);
    irq_enable <= 1'b1;
    i_spi_far_end.nss_q <= 1'b0;
    repeat (8) @(negedge core_clk);
    chk(ctrl_status, st(6'h0a));
    chk({7'h00, irq}, 8'h01);
    i_spi_far_end.nss_q = 1'b1;
    repeat (20) @(negedge core_clk);
    chk(ctrl_status, st(6'h0a));
    ctrl(st(6'h13));
    chk(ctrl_status, st(6'h13));
    $display("test fault done");
    dwr(a);
    repeat (20) @(negedge core_clk);
    ctrl(st(6'h03));
    chk(ctrl_status, st(6'h03));
    chk({6'h00, pins_out.sck_oe, ctrl_status[7]}, 8'h00);
    $display("test abort done");
    close_out();
  end
endmodule : spi_master_slave_port_tb_top

// ==== spi_pin_sync.sv ====
`timescale 1ns/1ns
module spi_pin_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // pins in, synchronised out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] first_reg;

  // two-stage synchroniser, first stage feeds second only
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      first_reg <= '0;
      sync_out <= '0;
    end else begin
      first_reg <= async_in;
      sync_out <= first_reg;
    end
  end

endmodule : spi_pin_sync

// ==== spi_port_pkg.sv ====
package spi_port_pkg;

  // ------------------------------------------------------------
  // control byte bit positions
  // ------------------------------------------------------------
  localparam int DONE_BIT = 7;
  localparam int MEN_BIT = 6;
  localparam int FAULT_BIT = 5;
  localparam int SEL_HI_BIT = 3;
  localparam int SEL_LO_BIT = 2;
  localparam int PEN_BIT = 0;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_HALF_NS = 40; // half period of generated sck
  localparam logic [3:0] SCK_HALF_CYCLES =
    4'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] LAST_BIT = 3'h7; // eight bits per byte

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } xfer_state_type;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic slave_select_pin;
  } pin_in_type;

  typedef struct packed {
    logic sck_out;
    logic sck_oe;
    logic mosi_out;
    logic mosi_oe;
    logic miso_out;
    logic miso_oe;
    logic nss_out;
    logic nss_oe;
  } pin_out_type;

  typedef struct packed {
    xfer_state_type st;
    logic done;
    logic men;
    logic fault;
    logic sel_hi;
    logic sel_lo;
    logic pen;
    logic [7:0] txbuf;
    logic tx_full;
    logic [7:0] shift;
    logic shift_full;
    logic [2:0] bitcnt;
    logic [3:0] div;
    logic sck_prev;
    logic [7:0] rxbuf;
    logic irq;
    pin_out_type pins;
  } state_type;

  localparam state_type STATE_RESET = '{
    st: ST_IDLE,
    done: 1'b0,
    men: 1'b0,
    fault: 1'b0,
    sel_hi: 1'b0,
    sel_lo: 1'b1, // multi-master select mode by default
    pen: 1'b0,
    txbuf: 8'h00,
    tx_full: 1'b0,
    shift: 8'h00,
    shift_full: 1'b0,
    bitcnt: 3'h0,
    div: 4'h0,
    sck_prev: 1'b0,
    rxbuf: 8'h00,
    irq: 1'b0,
    pins: 8'h02 // only nss_out idles high
  };

endpackage : spi_port_pkg
